// ### hdl/mdsf_pkg.sv
// Package: map, fields, reset values and types of the MAC event flags
package mdsf_pkg;

   // ---------------------------------------------------------------
   // Bus and address map
   // ---------------------------------------------------------------
   localparam int unsigned WB_AW = 32;
   localparam int unsigned WB_DW = 32;

   localparam logic [31:0] MAC_EVENT_FLAGS_PORT0_ADR = 32'h1006_4408;
   localparam logic [31:0] MAC_EVENT_FLAGS_PORT1_ADR = 32'h1006_5408;
   localparam logic [31:0] MAC_EVENT_FLAGS_PORT2_ADR = 32'h1006_6408;

   // Offsets from the bank base; the 64-bit flag register is two words
   localparam logic [31:0] OFS_FLAGS_LO  = 32'h0000_0000;
   localparam logic [31:0] OFS_FLAGS_HI  = 32'h0000_0004;
   localparam logic [31:0] OFS_CTRL      = 32'h0000_0020;
   localparam logic [31:0] OFS_WMARK     = 32'h0000_0024;
   localparam logic [31:0] OFS_SEED      = 32'h0000_0028;
   localparam logic [31:0] OFS_LFSR      = 32'h0000_002c;

   // ---------------------------------------------------------------
   // Field positions inside the 64-bit flag register
   // ---------------------------------------------------------------
   localparam int unsigned POS_PKT_DONE  = 26;
   localparam int unsigned POS_HIGH_MARK = 27;
   localparam int unsigned POS_LOW_MARK  = 28;
   localparam int unsigned POS_DSCR_IRQ  = 29;
   localparam int unsigned POS_RD_ERR    = 30;
   localparam int unsigned POS_BAD_DSCR  = 31;
   localparam int unsigned POS_RX_UNDR   = 40;
   localparam int unsigned POS_RX_OVR    = 41;
   localparam int unsigned POS_TX_UNDR   = 42;
   localparam int unsigned POS_TX_OVR    = 43;
   localparam int unsigned POS_LTCOL     = 44;
   localparam int unsigned POS_EXCOL     = 45;
   localparam int unsigned POS_CNTR_OVR  = 46;
   localparam int unsigned POS_CNTR_IDX  = 47;
   localparam int unsigned CNTR_IDX_W    = 5;

   // Index of each latched flag inside the sticky vector
   localparam int unsigned FLG_PKT_DONE  = 0;
   localparam int unsigned FLG_DSCR_IRQ  = 1;
   localparam int unsigned FLG_RD_ERR    = 2;
   localparam int unsigned FLG_BAD_DSCR  = 3;
   localparam int unsigned FLG_RX_UNDR   = 4;
   localparam int unsigned FLG_RX_OVR    = 5;
   localparam int unsigned FLG_TX_UNDR   = 6;
   localparam int unsigned FLG_TX_OVR    = 7;
   localparam int unsigned FLG_LTCOL     = 8;
   localparam int unsigned FLG_EXCOL     = 9;
   localparam int unsigned FLG_CNTR_OVR  = 10;
   localparam int unsigned NFLAGS        = 11;

   // Control register fields
   localparam int unsigned CTRL_PKT_FIFO = 0;
   localparam int unsigned CTRL_CH_EN    = 1;
   localparam int unsigned WMARK_LOW_LSB = 0;
   localparam int unsigned WMARK_HIGH_LSB = 8;
   localparam int unsigned DSCR_CNT_W    = 8;
   localparam int unsigned LFSR_W        = 16;

   // ---------------------------------------------------------------
   // Reset values and timing figures
   // ---------------------------------------------------------------
   localparam logic [NFLAGS-1:0]     FLAGS_RST = 11'h000;
   localparam logic [CNTR_IDX_W-1:0] IDX_RST   = 5'h00;
   localparam logic [1:0]            CTRL_RST  = 2'h0;
   localparam logic [15:0]           WMARK_RST = 16'h0000;
   localparam logic [LFSR_W-1:0]     SEED_RST  = 16'hace1;
   localparam logic [31:0]           WORD_ZERO = 32'h0000_0000;
   localparam logic [10:0]           MIN_FRAME_BYTES = 11'h040;
   localparam logic [4:0]            EXCOL_LIMIT     = 5'h10;
   localparam logic [4:0]            COL_CNT_RST     = 5'h00;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {CH_OFF, CH_RUN, CH_HALT} mdsf_ch_state_t;

   // Same-clock event and level inputs
   typedef struct packed {
      logic        tx_pkt_done;
      logic        tx_dscr_irq;
      logic        tx_rd_error;
      logic        tx_len_zero;
      logic        tx_first_no_sop;
      logic        tx_dscr_exhausted;
      logic        rx_fifo_rd;
      logic        rx_fifo_empty;
      logic        rx_fifo_wr;
      logic        rx_fifo_full;
      logic        tx_fifo_need;
      logic        tx_fifo_empty;
      logic        tx_fifo_wr;
      logic        tx_fifo_full;
      logic        tx_pkt_start;
      logic        tx_collision;
      logic [10:0] tx_byte_count;
      logic        rmon_ovfl;
      logic [4:0]  rmon_idx;
      logic        backoff_step;
   } mdsf_mac_ev_t;

endpackage

// ### hdl/mdsf_sticky.sv
// Sticky field cell: loaded on set, cleared on clear, set has priority
`timescale 1ns/1ps
module mdsf_sticky #(
   parameter int unsigned W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         set,
   input  wire logic [W-1:0] d,
   input  wire logic         clr,
   output logic      [W-1:0] q
);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else if (set) begin
         q <= d;
      end else if (clr) begin
         q <= '0;
      end
   end

endmodule

// ### hdl/mdsf_top.sv
// MAC event flag bank, bits 26 to 51, with its Wishbone slave and channel control
//
// Operation
// - Low flag word read returns contents, then clears latched flags.
// - Packet done latched on every second-channel completion.
// - High-mark bit live: count below high watermark.
// - Low-mark bit live: count below low watermark.
// - Descriptor interrupt-request processing sets descriptor flag.
// - Erroneous read data sets error, halts channel.
// - Zero length or missing start marker halts.
// - Descriptors exhausted mid-packet also bad, halts.
// - Receive FIFO read while empty sets underflow.
// - Receive write into full FIFO sets overflow.
// - Transmit needs data, FIFO empty: underflow.
// - Write into full transmit FIFO sets overflow.
// - Collision past minimum frame sets late flag.
// - Packet FIFO mode never sets collision flags.
// - Sixteenth collision of one packet sets excessive.
// - Software-loadable seed for backoff shift register.
// - Counter overflow sets flag, stores counter index.
// - Index field holds most recent overflowed counter.
// - Packet FIFO mode keeps counter overflow inactive.
// - Same layout in Ethernet and packet FIFO modes.
`timescale 1ns/1ps
module mdsf_top
   import mdsf_pkg::*;
#(
   parameter logic [31:0] BASE_ADR = MAC_EVENT_FLAGS_PORT0_ADR
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [WB_AW-1:0]      wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [WB_DW-1:0]      wb_dat_i,
   output logic      [WB_DW-1:0]      wb_dat_o,
   output logic                       wb_ack_o,
   input  wire mdsf_mac_ev_t          ev_i,
   input  wire logic [DSCR_CNT_W-1:0] tx_dscr_count_i,
   output logic                       tx_ch_enable_o,
   output logic                       tx_ch_halted_o,
   output logic                       pkt_fifo_mode_o,
   output logic      [LFSR_W-1:0]     backoff_lfsr_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [NFLAGS-1:0]     flag_set;
   logic [NFLAGS-1:0]     flag_q;
   logic [CNTR_IDX_W-1:0] cntr_idx_q;
   logic                  flags_clr;
   logic [31:0]           flags_hi_snap_r;
   logic [31:0]           flags_lo_now;
   logic [31:0]           flags_hi_now;

   logic [1:0]            ctrl_r;
   logic [15:0]           wmark_r;
   logic [LFSR_W-1:0]     seed_r;
   logic [LFSR_W-1:0]     lfsr_r;
   logic [LFSR_W-1:0]     lfsr_nxt;
   logic                  seed_load_r;

   mdsf_ch_state_t        ch_state_r;
   mdsf_ch_state_t        ch_state_nxt;
   logic                  ch_fault;

   logic [4:0]            col_cnt_r;
   logic [4:0]            col_cnt_inc;
   logic                  pkt_fifo_mode;
   logic                  col_event;

   logic                  bus_req;
   logic                  bus_rd;
   logic                  bus_wr;
   logic                  hit_lo;
   logic                  hit_hi;
   logic                  hit_ctrl;
   logic                  hit_wmark;
   logic                  hit_seed;
   logic                  hit_lfsr;
   logic [31:0]           wr_mask;
   logic [31:0]           rd_data;
   logic                  wb_ack_r;
   logic [31:0]           wb_dat_r;

   assign pkt_fifo_mode = ctrl_r[CTRL_PKT_FIFO];

   // ---------------------------------------------------------------
   // Wishbone decode
   // ---------------------------------------------------------------
   // Registered ack: answered one edge after the request
   assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_r;
   assign bus_rd    = bus_req && !wb_we_i;
   assign bus_wr    = bus_req && wb_we_i;
   assign hit_lo    = (wb_adr_i == BASE_ADR + OFS_FLAGS_LO);
   assign hit_hi    = (wb_adr_i == BASE_ADR + OFS_FLAGS_HI);
   assign hit_ctrl  = (wb_adr_i == BASE_ADR + OFS_CTRL);
   assign hit_wmark = (wb_adr_i == BASE_ADR + OFS_WMARK);
   assign hit_seed  = (wb_adr_i == BASE_ADR + OFS_SEED);
   assign hit_lfsr  = (wb_adr_i == BASE_ADR + OFS_LFSR);

   assign wr_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Low word read clears both halves and freezes the upper
   // one, so the high word read sees the same moment
   assign flags_clr = bus_rd && hit_lo;

   // ---------------------------------------------------------------
   // Set conditions of the latched flags
   // ---------------------------------------------------------------
   assign col_cnt_inc = col_cnt_r + 5'h01;
   assign col_event   = ev_i.tx_collision && !pkt_fifo_mode;

   always_comb begin
      flag_set               = '0;
      flag_set[FLG_PKT_DONE] = ev_i.tx_pkt_done;
      flag_set[FLG_DSCR_IRQ] = ev_i.tx_dscr_irq;
      flag_set[FLG_RD_ERR]   = ev_i.tx_rd_error;
      flag_set[FLG_BAD_DSCR] = ev_i.tx_len_zero || ev_i.tx_first_no_sop;
      if (ev_i.tx_dscr_exhausted) begin
         flag_set[FLG_BAD_DSCR] = 1'b1;
      end
      flag_set[FLG_RX_UNDR]  = ev_i.rx_fifo_rd && ev_i.rx_fifo_empty;
      flag_set[FLG_RX_OVR]   = ev_i.rx_fifo_wr && ev_i.rx_fifo_full;
      flag_set[FLG_TX_UNDR]  = ev_i.tx_fifo_need && ev_i.tx_fifo_empty;
      flag_set[FLG_TX_OVR]   = ev_i.tx_fifo_wr && ev_i.tx_fifo_full;
      flag_set[FLG_LTCOL]    = col_event
                               && (ev_i.tx_byte_count >= MIN_FRAME_BYTES);
      flag_set[FLG_EXCOL]    = col_event && !ev_i.tx_pkt_start
                               && (col_cnt_inc == EXCOL_LIMIT);
      flag_set[FLG_CNTR_OVR] = ev_i.rmon_ovfl && !pkt_fifo_mode;
   end

   // ---------------------------------------------------------------
   // Latched flag storage
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NFLAGS; gi++) begin : g_flag
         mdsf_sticky #(
            .W (1)
         ) u_flag (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .set     (flag_set[gi]),
            .d       (1'b1),
            .clr     (flags_clr),
            .q       (flag_q[gi])
         );
      end
   endgenerate

   // Each overflow overwrites the index: latest wins
   mdsf_sticky #(
      .W (CNTR_IDX_W)
   ) u_cntr_idx (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .set     (flag_set[FLG_CNTR_OVR]),
      .d       (ev_i.rmon_idx),
      .clr     (flags_clr),
      .q       (cntr_idx_q)
   );

   // ---------------------------------------------------------------
   // Collision attempt counter
   // ---------------------------------------------------------------
   // Saturates at the limit so a stuck medium cannot wrap and re-arm
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         col_cnt_r <= COL_CNT_RST;
      end else if (ev_i.tx_pkt_start || pkt_fifo_mode) begin
         col_cnt_r <= COL_CNT_RST;
      end else if (col_event && (col_cnt_r != EXCOL_LIMIT)) begin
         col_cnt_r <= col_cnt_inc;
      end
   end

   // ---------------------------------------------------------------
   // Second transmit channel run / halt control
   // ---------------------------------------------------------------
   assign ch_fault = flag_set[FLG_RD_ERR] || flag_set[FLG_BAD_DSCR];

   always_comb begin
      ch_state_nxt = ch_state_r;
      case (ch_state_r)
         CH_OFF: begin
            if (ctrl_r[CTRL_CH_EN]) begin
               ch_state_nxt = CH_RUN;
            end
         end
         CH_RUN: begin
            if (!ctrl_r[CTRL_CH_EN]) begin
               ch_state_nxt = CH_OFF;
            end else if (ch_fault) begin
               ch_state_nxt = CH_HALT;
            end
         end
         CH_HALT: begin
            // Only a disable releases the halt; re-enable then restarts
            if (!ctrl_r[CTRL_CH_EN]) begin
               ch_state_nxt = CH_OFF;
            end
         end
         default: begin
            ch_state_nxt = CH_OFF;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ch_state_r     <= CH_OFF;
         tx_ch_enable_o <= 1'b0;
         tx_ch_halted_o <= 1'b0;
      end else begin
         ch_state_r     <= ch_state_nxt;
         tx_ch_enable_o <= (ch_state_nxt == CH_RUN);
         tx_ch_halted_o <= (ch_state_nxt == CH_HALT);
      end
   end

   // ---------------------------------------------------------------
   // Software control registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
      end else if (bus_wr && hit_ctrl && wb_sel_i[0]) begin
         ctrl_r <= wb_dat_i[1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wmark_r <= WMARK_RST;
      end else if (bus_wr && hit_wmark) begin
         wmark_r <= (wmark_r & ~wr_mask[15:0]) | (wb_dat_i[15:0] & wr_mask[15:0]);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         seed_r      <= SEED_RST;
         seed_load_r <= 1'b0;
      end else begin
         seed_load_r <= bus_wr && hit_seed && (wb_sel_i[1:0] != 2'h0);
         if (bus_wr && hit_seed) begin
            seed_r <= (seed_r & ~wr_mask[15:0]) | (wb_dat_i[15:0] & wr_mask[15:0]);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pkt_fifo_mode_o <= 1'b0;
      end else begin
         pkt_fifo_mode_o <= pkt_fifo_mode;
      end
   end

   // ---------------------------------------------------------------
   // Random backoff shift register
   // ---------------------------------------------------------------
   // All-zero seed would lock the register; reset seed instead
   always_comb begin
      lfsr_nxt = lfsr_r;
      if (seed_load_r) begin
         lfsr_nxt = (seed_r == '0) ? SEED_RST : seed_r;
      end else if (ev_i.backoff_step) begin
         lfsr_nxt = {lfsr_r[LFSR_W-2:0],
                     lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         lfsr_r         <= SEED_RST;
         backoff_lfsr_o <= SEED_RST;
      end else begin
         lfsr_r         <= lfsr_nxt;
         backoff_lfsr_o <= lfsr_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Flag register images and high word snapshot
   // ---------------------------------------------------------------
   // Same layout whatever the mode; mode only gates the set conditions
   always_comb begin
      flags_lo_now                = WORD_ZERO;
      flags_lo_now[POS_PKT_DONE]  = flag_q[FLG_PKT_DONE];
      flags_lo_now[POS_HIGH_MARK] = (tx_dscr_count_i
                                     < wmark_r[WMARK_HIGH_LSB +: DSCR_CNT_W]);
      flags_lo_now[POS_LOW_MARK]  = (tx_dscr_count_i
                                     < wmark_r[WMARK_LOW_LSB +: DSCR_CNT_W]);
      flags_lo_now[POS_DSCR_IRQ]  = flag_q[FLG_DSCR_IRQ];
      flags_lo_now[POS_RD_ERR]    = flag_q[FLG_RD_ERR];
      flags_lo_now[POS_BAD_DSCR]  = flag_q[FLG_BAD_DSCR];
   end

   always_comb begin
      flags_hi_now                   = WORD_ZERO;
      flags_hi_now[POS_RX_UNDR - 32] = flag_q[FLG_RX_UNDR];
      flags_hi_now[POS_RX_OVR - 32]  = flag_q[FLG_RX_OVR];
      flags_hi_now[POS_TX_UNDR - 32] = flag_q[FLG_TX_UNDR];
      flags_hi_now[POS_TX_OVR - 32]  = flag_q[FLG_TX_OVR];
      flags_hi_now[POS_LTCOL - 32]   = flag_q[FLG_LTCOL];
      flags_hi_now[POS_EXCOL - 32]   = flag_q[FLG_EXCOL];
      flags_hi_now[POS_CNTR_OVR - 32] = flag_q[FLG_CNTR_OVR];
      flags_hi_now[POS_CNTR_IDX - 32 +: CNTR_IDX_W] = cntr_idx_q;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flags_hi_snap_r <= WORD_ZERO;
      end else if (flags_clr) begin
         flags_hi_snap_r <= flags_hi_now;
      end
   end

   // ---------------------------------------------------------------
   // Read mux and bus answer
   // ---------------------------------------------------------------
   always_comb begin
      rd_data = WORD_ZERO;
      if (hit_lo) begin
         rd_data = flags_lo_now;
      end else if (hit_hi) begin
         rd_data = flags_hi_snap_r;
      end else if (hit_ctrl) begin
         rd_data[1:0] = ctrl_r;
      end else if (hit_wmark) begin
         rd_data[15:0] = wmark_r;
      end else if (hit_seed) begin
         rd_data[15:0] = seed_r;
      end else if (hit_lfsr) begin
         rd_data[15:0] = lfsr_r;
      end
   end

   // Unmapped addresses ack with zero data; the bus never hangs
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wb_ack_r <= 1'b0;
         wb_dat_r <= WORD_ZERO;
      end else begin
         wb_ack_r <= bus_req;
         if (bus_rd) begin
            wb_dat_r <= rd_data;
         end else begin
            wb_dat_r <= WORD_ZERO;
         end
      end
   end

   assign wb_ack_o = wb_ack_r;
   assign wb_dat_o = wb_dat_r;

endmodule

// ### sim/mdsf_top_assertions.sv
// Checker: properties of the MAC event flag bank
`timescale 1ns/1ps
module mdsf_top_assertions
   import mdsf_pkg::*;
#(
   parameter logic [31:0] BASE_ADR = MAC_EVENT_FLAGS_PORT0_ADR
) (
   input wire logic              ref_clk,
   input wire logic              rst_n,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [WB_AW-1:0]  wb_adr_i,
   input wire logic [3:0]        wb_sel_i,
   input wire logic [WB_DW-1:0]  wb_dat_i,
   input wire logic [WB_DW-1:0]  wb_dat_o,
   input wire logic              wb_ack_o,
   input wire mdsf_mac_ev_t      ev_i,
   input wire logic              tx_ch_enable_o,
   input wire logic              tx_ch_halted_o,
   input wire logic [LFSR_W-1:0] backoff_lfsr_o
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic rd_lo, rd_hi, ctl_off, ch_run;
   assign rd_lo = wb_ack_o && !wb_we_i && wb_adr_i == BASE_ADR;
   assign rd_hi = wb_ack_o && !wb_we_i && wb_adr_i == BASE_ADR + OFS_FLAGS_HI;
   // Write clearing the enable bit
   assign ctl_off = wb_ack_o && wb_we_i && wb_adr_i == BASE_ADR + OFS_CTRL
                    && wb_sel_i[0] && !wb_dat_i[CTRL_CH_EN];
   // A disable in the same cycle as a fault wins, so no halt then
   assign ch_run = tx_ch_enable_o && !ctl_off;

   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("late ack");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == WORD_ZERO)
      else $error("stray read data");
   AST_LO_RSVD: assert property (rd_lo |-> wb_dat_o[25:0] == 26'h0)
      else $error("low reserved set");
   AST_HI_RSVD: assert property (rd_hi |-> {wb_dat_o[31:20], wb_dat_o[7:0]} == 20'h0)
      else $error("high reserved set");
   AST_DERR_HALT: assert property (ch_run && ev_i.tx_rd_error
      |=> tx_ch_halted_o && !tx_ch_enable_o) else $error("no error halt");
   AST_DZERO_HALT: assert property (ch_run
      && (ev_i.tx_len_zero || ev_i.tx_first_no_sop) |=> tx_ch_halted_o && !tx_ch_enable_o)
      else $error("no bad-descriptor halt");
   AST_EXH_HALT: assert property (ch_run && ev_i.tx_dscr_exhausted |=> tx_ch_halted_o)
      else $error("no exhaust halt");
   AST_HALT_EXIT: assert property ($fell(tx_ch_halted_o) |-> $past(ctl_off))
      else $error("halt left early");
   AST_LFSR_STEP: assert property (ev_i.backoff_step && !(wb_ack_o && wb_we_i)
      |=> backoff_lfsr_o == {$past(backoff_lfsr_o[14:0]), ^($past(backoff_lfsr_o) & 16'hb400)})
      else $error("backoff step wrong");
endmodule

// ### sim/mdsf_top_tb_top.sv
// Testbench of the MAC event flag bank
`timescale 1ns/1ps
module mdsf_top_tb_top;
   import mdsf_pkg::*;
   localparam logic [31:0] BASE = MAC_EVENT_FLAGS_PORT0_ADR;
   logic         ref_clk = 1'h0;
   logic         rst_n = 1'h0;
   logic         wb_cyc_i = 1'h0;
   logic         wb_stb_i = 1'h0;
   logic         wb_we_i = 1'h0;
   logic [31:0]  wb_adr_i = 32'h0;
   logic [3:0]   wb_sel_i = 4'hf;
   logic [31:0]  wb_dat_i = 32'h0;
   logic [31:0]  wb_dat_o;
   logic         wb_ack_o;
   mdsf_mac_ev_t ev_i = '0;
   logic [7:0]   tx_dscr_count_i = 8'h00;
   logic         tx_ch_enable_o;
   logic         tx_ch_halted_o;
   logic         pkt_fifo_mode_o;
   logic [15:0]  backoff_lfsr_o;
   int           fail_count = 0;
   int           checks = 0;
   logic [31:0]  lo, hi, q;
   logic [63:0]  v, x;
   logic [15:0]  s;
   logic [7:0]   c8;
   mdsf_mac_ev_t e;
   int           k;

   always #5 ref_clk = ~ref_clk;

   mdsf_top #(.BASE_ADR(BASE)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ev_i(ev_i),
      .tx_dscr_count_i(tx_dscr_count_i), .tx_ch_enable_o(tx_ch_enable_o),
      .tx_ch_halted_o(tx_ch_halted_o), .pkt_fifo_mode_o(pkt_fifo_mode_o),
      .backoff_lfsr_o(backoff_lfsr_o));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic end_of_test;
      if (fail_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] want);
      checks++;
      if (got !== want) begin
         $display("BAD %0t got %h want %h", $time, got, want);
         fail_count++;
      end
   endtask

   // Starts after an edge; ends one idle edge after ack
   task automatic wb(input logic we, input logic [31:0] ofs, input logic [31:0] d,
                     output logic [31:0] r);
      int t;
      t = 0;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= BASE + ofs;
      wb_dat_i <= d;
      do begin
         @(posedge ref_clk);
         t++;
      end while (wb_ack_o !== 1'h1 && t < 20);
      if (t >= 20) begin
         $display("BAD %0t no bus answer", $time);
         fail_count++;
      end
      r = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [31:0] ofs, input logic [31:0] d);
      wb(1'h1, ofs, d, q);
   endtask

   // Low word first: it clears and snapshots
   task automatic rd64(output logic [63:0] r);
      wb(1'h0, OFS_FLAGS_LO, 32'h0, lo);
      wb(1'h0, OFS_FLAGS_HI, 32'h0, hi);
      r = {hi, lo};
   endtask

   task automatic pulse(input mdsf_mac_ev_t p);
      ev_i <= p;
      @(posedge ref_clk);
      ev_i <= '0;
      @(posedge ref_clk);
   endtask

   task automatic build(input int c, output mdsf_mac_ev_t p, output logic [63:0] r);
      p = '0;
      r = 64'h0;
      case (c)
         0: begin p.tx_pkt_done = 1'h1; r[POS_PKT_DONE] = 1'h1; end
         1: begin p.tx_dscr_irq = 1'h1; r[POS_DSCR_IRQ] = 1'h1; end
         2: begin p.tx_rd_error = 1'h1; r[POS_RD_ERR] = 1'h1; end
         3: begin p.tx_len_zero = 1'h1; r[POS_BAD_DSCR] = 1'h1; end
         4: begin p.tx_first_no_sop = 1'h1; r[POS_BAD_DSCR] = 1'h1; end
         5: begin p.tx_dscr_exhausted = 1'h1; r[POS_BAD_DSCR] = 1'h1; end
         6: begin p.rx_fifo_rd = 1'h1; p.rx_fifo_empty = 1'h1; r[POS_RX_UNDR] = 1'h1; end
         7: begin p.rx_fifo_wr = 1'h1; p.rx_fifo_full = 1'h1; r[POS_RX_OVR] = 1'h1; end
         8: begin p.tx_fifo_need = 1'h1; p.tx_fifo_empty = 1'h1; r[POS_TX_UNDR] = 1'h1; end
         9: begin p.tx_fifo_wr = 1'h1; p.tx_fifo_full = 1'h1; r[POS_TX_OVR] = 1'h1; end
         10: begin
            p.tx_collision = 1'h1;
            p.tx_byte_count = MIN_FRAME_BYTES + 11'($urandom_range(0, 1983));
            r[POS_LTCOL] = 1'h1;
         end
         11: begin
            p.rmon_ovfl = 1'h1;
            p.rmon_idx = 5'($urandom);
            r[POS_CNTR_OVR] = 1'h1;
            r[51:47] = p.rmon_idx;
         end
         12: p.rx_fifo_rd = 1'h1;
         default: begin p.tx_collision = 1'h1; p.tx_byte_count = MIN_FRAME_BYTES - 11'h001; end
      endcase
   endtask

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      #100000;
      $display("BAD %0t watchdog expired", $time);
      fail_count++;
      end_of_test();
   end

   initial begin
      void'($urandom(80));
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      rd64(v);
      chk(v, 64'h0);
      wb(1'h0, OFS_LFSR, 32'h0, q);
      chk(q, {16'h0, SEED_RST});
      wb(1'h0, 32'h0000_0040, 32'h0, q);
      chk(q, 64'h0);
      for (k = 0; k < 14; k++) begin
         build(k, e, x);
         pulse(e);
         rd64(v);
         chk(v, x);
         rd64(v);
         chk(v, 64'h0);
      end
      build(11, e, x);
      e.rmon_idx = 5'h1f;
      pulse(e);
      build(11, e, x);
      pulse(e);
      rd64(v);
      chk(v, x);
      e = '0;
      e.tx_pkt_start = 1'h1;
      pulse(e);
      build(13, e, x);
      repeat (15) pulse(e);
      rd64(v);
      chk(v, x);
      pulse(e);
      rd64(v);
      chk(v, 64'h1 << POS_EXCOL);
      for (k = 0; k < 6; k++) begin
         s = 16'($urandom);
         c8 = (k == 0) ? s[15:8] : 8'($urandom);
         tx_dscr_count_i <= c8;
         wr(OFS_WMARK, {16'h0, s});
         rd64(v);
         chk(v[28:27], {c8 < s[7:0], c8 < s[15:8]});
      end
      rd64(v);
      chk(v[28:27], {c8 < s[7:0], c8 < s[15:8]});
      wr(OFS_WMARK, 32'h0);
      for (k = 2; k < 6; k++) begin
         wr(OFS_CTRL, 32'h2);
         chk(tx_ch_enable_o, 64'h1);
         build(k, e, x);
         pulse(e);
         chk({tx_ch_halted_o, tx_ch_enable_o}, 64'h2);
         wr(OFS_CTRL, 32'h2);
         chk({tx_ch_halted_o, tx_ch_enable_o}, 64'h2);
         wr(OFS_CTRL, 32'h0);
         wr(OFS_CTRL, 32'h2);
         chk({tx_ch_halted_o, tx_ch_enable_o}, 64'h1);
         wr(OFS_CTRL, 32'h0);
      end
      rd64(v);
      // Event on the clearing read's edge
      e = '0;
      e.tx_pkt_done = 1'h1;
      ev_i <= e;
      fork
         wb(1'h0, OFS_FLAGS_LO, 32'h0, lo);
         begin
            @(posedge ref_clk);
            ev_i <= '0;
         end
      join
      rd64(v);
      chk(v, 64'h1 << POS_PKT_DONE);
      wr(OFS_CTRL, 32'h1);
      e = '0;
      e.tx_pkt_start = 1'h1;
      pulse(e);
      build(11, e, x);
      e.tx_collision = 1'h1;
      e.tx_byte_count = 11'h100;
      e.tx_pkt_done = 1'h1;
      repeat (16) pulse(e);
      chk(pkt_fifo_mode_o, 64'h1);
      rd64(v);
      chk(v, 64'h1 << POS_PKT_DONE);
      wr(OFS_CTRL, 32'h0);
      s = 16'($urandom) | 16'h0001;
      wr(OFS_SEED, {16'h0, s});
      wb(1'h0, OFS_LFSR, 32'h0, q);
      chk(q, {48'h0, s});
      e = '0;
      e.backoff_step = 1'h1;
      pulse(e);
      wb(1'h0, OFS_LFSR, 32'h0, q);
      chk(q, {48'h0, s[14:0], ^(s & 16'hb400)});
      end_of_test();
   end
endmodule

bind mdsf_top mdsf_top_assertions #(.BASE_ADR(BASE_ADR)) chk_u (.ref_clk(ref_clk),
   .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .ev_i(ev_i), .tx_ch_enable_o(tx_ch_enable_o),
   .tx_ch_halted_o(tx_ch_halted_o), .backoff_lfsr_o(backoff_lfsr_o));
